// File: inc/cmp_pkg.sv
package cmp_pkg;
   // Byte register indices. Printed offsets are not all multiples of four, so a byte-wide
   // plain port is used: each address selects one byte.
   localparam logic [11:0] ADDR_A_CTRL   = 12'h110;
   localparam logic [11:0] ADDR_A_ADDR   = 12'h115;
   localparam logic [11:0] ADDR_A_DATA   = 12'h118;
   localparam logic [11:0] ADDR_A_MASK   = 12'h11C;
   localparam logic [11:0] ADDR_B_CTRL   = 12'h120;
   localparam logic [11:0] ADDR_B_ADDR   = 12'h125;
   localparam logic [11:0] ADDR_IRQ_STAT = 12'h130;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h131;
   localparam logic [11:0] ADDR_ARMED    = 12'h132;

   localparam int BIT_ENABLE = 0;
   localparam int BIT_DIR_QUAL = 2;
   localparam int BIT_DIR = 3;
   localparam int BIT_PC_SEL = 5;
   localparam int BIT_INV_DATA = 6;

   localparam logic [31:0] DATA_RESET = 32'h0000_0000;
   localparam logic [23:0] ADDR_RESET = 24'h00_0000;
   localparam logic [7:0]  CTRL_RESET = 8'h00;
   localparam logic [7:0]  CTRL_A_WMASK = 8'h6D;
   localparam logic [7:0]  CTRL_B_WMASK = 8'h2D;
endpackage

// File: rtl/cmp_match.sv
`timescale 1ns/1ps
module cmp_match (
   input  wire logic [7:0]  ctrl,
   input  wire logic [23:0] cmp_addr,
   input  wire logic        use_data,
   input  wire logic [31:0] data_value,
   input  wire logic [31:0] data_mask,
   input  wire logic [23:0] pc_addr,
   input  wire logic        pc_exec,
   input  wire logic [23:0] bus_addr,
   input  wire logic [31:0] bus_data,
   input  wire logic        bus_valid,
   input  wire logic        bus_rw,
   output logic             hit
);
   logic addr_ok;
   logic pc_ok;
   logic dir_ok;
   logic data_eq;
   logic data_ok;

   always_comb begin
      pc_ok   = pc_exec && (pc_addr == cmp_addr);
      addr_ok = bus_valid && (bus_addr == cmp_addr);
      dir_ok  = !ctrl[cmp_pkg::BIT_DIR_QUAL] || (bus_rw == ctrl[cmp_pkg::BIT_DIR]);
      data_eq = ((bus_data ^ data_value) & data_mask) == 32'h0000_0000;
      data_ok = !use_data || (data_eq ^ ctrl[cmp_pkg::BIT_INV_DATA]);
      if (!ctrl[cmp_pkg::BIT_ENABLE]) begin
         hit = 1'b0;
      end else if (ctrl[cmp_pkg::BIT_PC_SEL]) begin
         hit = pc_ok;
      end else begin
         hit = addr_ok && dir_ok && data_ok;
      end
   end
endmodule

// File: rtl/debug_bus_comparators_ab.sv
// What this block does
// - Address registers hold 24 compare bits.
// - Always readable; writes ignored while armed, except to IRQ status and IRQ mask.
// - Data value byte 0 is MSB.
// - Data mask byte 0 is MSB.
// - Data bit used only when masked in.
// - Mask one compares the data bit.
// - Select bit picks data or PC address.
// - Direction bit: zero write, one read.
// - Qualify enable includes direction in compare.
// - Comparator B silent unless enabled.
// - Qualified match needs bus direction equal.
// - Range mode: B uses A's control.
// - Inverted bit matches on data difference.
// - A drives line zero, B line one.
// - PC match when opcode reaches execution.
`timescale 1ns/1ps
module debug_bus_comparators_ab (
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic [11:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   input  wire logic        debug_unit_armed,
   input  wire logic        ab_range_mode,
   input  wire logic [23:0] pc_addr,
   input  wire logic        pc_exec,
   input  wire logic [23:0] bus_addr,
   input  wire logic [31:0] bus_data,
   input  wire logic        bus_valid,
   input  wire logic        bus_rw,
   output logic             match_0,
   output logic             match_1,
   output logic             irq
);
   logic [7:0]  cmp_a_control;
   logic [23:0] cmp_a_address;
   logic [31:0] cmp_a_data_value;
   logic [31:0] cmp_a_data_mask;
   logic [7:0]  cmp_b_control;
   logic [23:0] cmp_b_address;
   logic [1:0]  irq_status;
   logic [1:0]  irq_mask;
   logic [7:0]  next_cmp_a_control;
   logic [23:0] next_cmp_a_address;
   logic [31:0] next_cmp_a_data_value;
   logic [31:0] next_cmp_a_data_mask;
   logic [7:0]  next_cmp_b_control;
   logic [23:0] next_cmp_b_address;
   logic [1:0]  next_irq_status;
   logic [1:0]  next_irq_mask;
   logic [7:0]  next_reg_rdata;
   logic        next_match_0;
   logic        next_match_1;
   logic        hit_a;
   logic        hit_b;
   logic [7:0]  ctrl_b_eff;
   logic        wr_ok;

   assign ctrl_b_eff = ab_range_mode ? cmp_a_control : cmp_b_control;

   cmp_match u_cmp_a (
      .ctrl       (cmp_a_control),
      .cmp_addr   (cmp_a_address),
      .use_data   (1'b1),
      .data_value (cmp_a_data_value),
      .data_mask  (cmp_a_data_mask),
      .pc_addr    (pc_addr),
      .pc_exec    (pc_exec),
      .bus_addr   (bus_addr),
      .bus_data   (bus_data),
      .bus_valid  (bus_valid),
      .bus_rw     (bus_rw),
      .hit        (hit_a)
   );

   cmp_match u_cmp_b (
      .ctrl       (ctrl_b_eff),
      .cmp_addr   (cmp_b_address),
      .use_data   (1'b0),
      .data_value (cmp_pkg::DATA_RESET),
      .data_mask  (cmp_pkg::DATA_RESET),
      .pc_addr    (pc_addr),
      .pc_exec    (pc_exec),
      .bus_addr   (bus_addr),
      .bus_data   (bus_data),
      .bus_valid  (bus_valid),
      .bus_rw     (bus_rw),
      .hit        (hit_b)
   );

   // In range mode the line outputs are held off; the range match is built elsewhere.
   always_comb begin
      next_match_0 = hit_a && !ab_range_mode;
      next_match_1 = hit_b && !ab_range_mode;
   end

   always_comb begin
      wr_ok = reg_wr && !debug_unit_armed;
      next_cmp_a_control    = cmp_a_control;
      next_cmp_a_address    = cmp_a_address;
      next_cmp_a_data_value = cmp_a_data_value;
      next_cmp_a_data_mask  = cmp_a_data_mask;
      next_cmp_b_control    = cmp_b_control;
      next_cmp_b_address    = cmp_b_address;
      next_irq_mask         = irq_mask;
      next_irq_status       = irq_status;
      next_reg_rdata        = 8'h00;
      if (reg_wr && reg_addr == cmp_pkg::ADDR_IRQ_STAT) begin
         next_irq_status = irq_status & ~reg_wdata[1:0];
      end
      // Set after clear, so an event in the clearing cycle is kept.
      next_irq_status = next_irq_status | {next_match_1, next_match_0};
      if (reg_wr && reg_addr == cmp_pkg::ADDR_IRQ_MASK) begin
         next_irq_mask = reg_wdata[1:0];
      end
      if (wr_ok) begin
         case (reg_addr)
            cmp_pkg::ADDR_A_CTRL:       next_cmp_a_control = reg_wdata & cmp_pkg::CTRL_A_WMASK;
            cmp_pkg::ADDR_B_CTRL:       next_cmp_b_control = reg_wdata & cmp_pkg::CTRL_B_WMASK;
            cmp_pkg::ADDR_A_ADDR:       next_cmp_a_address[23:16] = reg_wdata;
            cmp_pkg::ADDR_A_ADDR + 12'h1: next_cmp_a_address[15:8] = reg_wdata;
            cmp_pkg::ADDR_A_ADDR + 12'h2: next_cmp_a_address[7:0] = reg_wdata;
            cmp_pkg::ADDR_B_ADDR:       next_cmp_b_address[23:16] = reg_wdata;
            cmp_pkg::ADDR_B_ADDR + 12'h1: next_cmp_b_address[15:8] = reg_wdata;
            cmp_pkg::ADDR_B_ADDR + 12'h2: next_cmp_b_address[7:0] = reg_wdata;
            cmp_pkg::ADDR_A_DATA:       next_cmp_a_data_value[31:24] = reg_wdata;
            cmp_pkg::ADDR_A_DATA + 12'h1: next_cmp_a_data_value[23:16] = reg_wdata;
            cmp_pkg::ADDR_A_DATA + 12'h2: next_cmp_a_data_value[15:8] = reg_wdata;
            cmp_pkg::ADDR_A_DATA + 12'h3: next_cmp_a_data_value[7:0] = reg_wdata;
            cmp_pkg::ADDR_A_MASK:       next_cmp_a_data_mask[31:24] = reg_wdata;
            cmp_pkg::ADDR_A_MASK + 12'h1: next_cmp_a_data_mask[23:16] = reg_wdata;
            cmp_pkg::ADDR_A_MASK + 12'h2: next_cmp_a_data_mask[15:8] = reg_wdata;
            cmp_pkg::ADDR_A_MASK + 12'h3: next_cmp_a_data_mask[7:0] = reg_wdata;
            default: next_reg_rdata = 8'h00;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            cmp_pkg::ADDR_A_CTRL:         next_reg_rdata = cmp_a_control;
            cmp_pkg::ADDR_B_CTRL:         next_reg_rdata = cmp_b_control;
            cmp_pkg::ADDR_A_ADDR:         next_reg_rdata = cmp_a_address[23:16];
            cmp_pkg::ADDR_A_ADDR + 12'h1: next_reg_rdata = cmp_a_address[15:8];
            cmp_pkg::ADDR_A_ADDR + 12'h2: next_reg_rdata = cmp_a_address[7:0];
            cmp_pkg::ADDR_B_ADDR:         next_reg_rdata = cmp_b_address[23:16];
            cmp_pkg::ADDR_B_ADDR + 12'h1: next_reg_rdata = cmp_b_address[15:8];
            cmp_pkg::ADDR_B_ADDR + 12'h2: next_reg_rdata = cmp_b_address[7:0];
            cmp_pkg::ADDR_A_DATA:         next_reg_rdata = cmp_a_data_value[31:24];
            cmp_pkg::ADDR_A_DATA + 12'h1: next_reg_rdata = cmp_a_data_value[23:16];
            cmp_pkg::ADDR_A_DATA + 12'h2: next_reg_rdata = cmp_a_data_value[15:8];
            cmp_pkg::ADDR_A_DATA + 12'h3: next_reg_rdata = cmp_a_data_value[7:0];
            cmp_pkg::ADDR_A_MASK:         next_reg_rdata = cmp_a_data_mask[31:24];
            cmp_pkg::ADDR_A_MASK + 12'h1: next_reg_rdata = cmp_a_data_mask[23:16];
            cmp_pkg::ADDR_A_MASK + 12'h2: next_reg_rdata = cmp_a_data_mask[15:8];
            cmp_pkg::ADDR_A_MASK + 12'h3: next_reg_rdata = cmp_a_data_mask[7:0];
            cmp_pkg::ADDR_IRQ_STAT:       next_reg_rdata = {6'h00, irq_status};
            cmp_pkg::ADDR_IRQ_MASK:       next_reg_rdata = {6'h00, irq_mask};
            cmp_pkg::ADDR_ARMED:          next_reg_rdata = {7'h00, debug_unit_armed};
            default:                      next_reg_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cmp_a_control    <= cmp_pkg::CTRL_RESET;
         cmp_b_control    <= cmp_pkg::CTRL_RESET;
         cmp_a_address    <= cmp_pkg::ADDR_RESET;
         cmp_b_address    <= cmp_pkg::ADDR_RESET;
         cmp_a_data_value <= cmp_pkg::DATA_RESET;
         cmp_a_data_mask  <= cmp_pkg::DATA_RESET;
         irq_status       <= 2'h0;
         irq_mask         <= 2'h0;
         reg_rdata        <= 8'h00;
         match_0          <= 1'b0;
         match_1          <= 1'b0;
         irq              <= 1'b0;
      end else begin
         cmp_a_control    <= next_cmp_a_control;
         cmp_b_control    <= next_cmp_b_control;
         cmp_a_address    <= next_cmp_a_address;
         cmp_b_address    <= next_cmp_b_address;
         cmp_a_data_value <= next_cmp_a_data_value;
         cmp_a_data_mask  <= next_cmp_a_data_mask;
         irq_status       <= next_irq_status;
         irq_mask         <= next_irq_mask;
         reg_rdata        <= next_reg_rdata;
         match_0          <= next_match_0;
         match_1          <= next_match_1;
         irq              <= |(next_irq_status & next_irq_mask);
      end
   end
endmodule

// File: tb/cpu_bus_model.sv
`timescale 1ns/1ps
module cpu_bus_model (
   input  wire logic        clk_sys,
   output logic [23:0]      pc_addr,
   output logic             pc_exec,
   output logic [23:0]      bus_addr,
   output logic [31:0]      bus_data,
   output logic             bus_valid,
   output logic             bus_rw
);
   initial begin
      {pc_addr, pc_exec, bus_addr, bus_data, bus_valid, bus_rw} = '0;
   end
   // One access per call, started on an edge; on release the strobes go low and address, data and rw lines take the inverse of the call's values.
   task acc(input logic [23:0] a, input logic [31:0] d, input logic rw, input logic pc);
      if (pc) begin
         pc_addr <= a;
         pc_exec <= 1'b1;
      end else begin
         {bus_addr, bus_data, bus_rw, bus_valid} <= {a, d, rw, 1'b1};
      end
      @(posedge clk_sys);
      {pc_exec, bus_valid, bus_addr, bus_data, pc_addr, bus_rw} <= {2'b00, ~a, ~d, ~a, ~rw};
   endtask
endmodule

// File: tb/debug_bus_comparators_ab_monitor.sv
`timescale 1ns/1ps
module debug_bus_comparators_ab_monitor (
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic [11:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_rdata,
   input  wire logic        debug_unit_armed,
   input  wire logic        ab_range_mode,
   input  wire logic        pc_exec,
   input  wire logic        bus_valid,
   input  wire logic        match_0,
   input  wire logic        match_1,
   input  wire logic        irq
);
   logic [7:0] data_msb;
   logic [7:0] irq_en;
   logic [7:0] ctrl_b;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Shadows follow only the writes that the block must accept.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         {data_msb, irq_en, ctrl_b} <= '0;
      end else if (reg_wr) begin
         if (reg_addr == cmp_pkg::ADDR_A_DATA && !debug_unit_armed) data_msb <= reg_wdata;
         if (reg_addr == cmp_pkg::ADDR_B_CTRL && !debug_unit_armed) ctrl_b <= reg_wdata;
         if (reg_addr == cmp_pkg::ADDR_IRQ_MASK) irq_en <= reg_wdata;
      end
   end
   sequence mask_lsb_wr;
      reg_wr && !debug_unit_armed && reg_addr == cmp_pkg::ADDR_A_MASK + 12'h003;
   endsequence
   sequence mask_lsb_rd;
      reg_rd && reg_addr == cmp_pkg::ADDR_A_MASK + 12'h003;
   endsequence
   a_data_msb_read: assert property (
      reg_rd && reg_addr == cmp_pkg::ADDR_A_DATA |=> reg_rdata == $past(data_msb))
      else $error("data byte 0 readback wrong");
   a_mask_lsb_order: assert property (
      mask_lsb_wr ##1 mask_lsb_rd |=> reg_rdata == $past(reg_wdata, 2))
      else $error("mask byte 3 readback wrong");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   a_unmapped_zero: assert property (
      reg_rd && reg_addr == 12'h000 |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_match_cause: assert property (
      !bus_valid && !pc_exec |=> !match_0 && !match_1) else $error("match without access");
   a_range_quiet: assert property (
      ab_range_mode |=> !match_0 && !match_1) else $error("match line in range mode");
   a_b_disabled: assert property (
      !ctrl_b[cmp_pkg::BIT_ENABLE] |=> !match_1) else $error("disabled comparator b matched");
   a_irq_masked: assert property (irq_en[1:0] == 2'b00 |-> !irq) else $error("irq while all masked");
endmodule
bind debug_bus_comparators_ab debug_bus_comparators_ab_monitor i_mon (.clk_sys, .sys_rst,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .debug_unit_armed, .ab_range_mode,
   .pc_exec, .bus_valid, .match_0, .match_1, .irq);

// File: tb/debug_bus_comparators_ab_tb_top.sv
`timescale 1ns/1ps
module debug_bus_comparators_ab_tb_top;
   logic        clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, arm = 1'b0;
   logic        rng = 1'b0, match_0, match_1, irq, pc_exec, bus_valid, bus_rw;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata;
   logic [23:0] pc_addr, bus_addr;
   logic [31:0] bus_data;
   int          error_cnt = 0, compares = 0, cyc = 0;
   localparam logic [11:0] rows [10] = '{12'h004, 12'h015, 12'h011, 12'h051, 12'h054,
                                         12'h0D5, 12'h0D0, 12'h213, 12'h210, 12'h2D3};
   always #2.5 clk_sys = ~clk_sys;
   cpu_bus_model i_cpu (.clk_sys, .pc_addr, .pc_exec, .bus_addr, .bus_data, .bus_valid, .bus_rw);
   debug_bus_comparators_ab i_dut (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .debug_unit_armed(arm), .ab_range_mode(rng), .pc_addr, .pc_exec, .bus_addr,
      .bus_data, .bus_valid, .bus_rw, .match_0, .match_1, .irq);
   task give_verdict;
      if (error_cnt == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // A write leaves its strobe up so that a read may follow at once; idle lowers it.
   task wr(input logic [11:0] a, input logic [7:0] d);
      {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, 2'b10};
      @(posedge clk_sys);
   endtask
   task idle;
      {reg_wr, reg_rd} <= 2'b00;
      @(posedge clk_sys);
   endtask
   task rd(input logic [11:0] a, input logic [7:0] e);
      {reg_addr, reg_wr, reg_rd} <= {a, 2'b01};
      @(posedge clk_sys);
      {reg_wr, reg_rd} <= 2'b00;
      #1 chk(reg_rdata, e);
      @(posedge clk_sys);
   endtask
   task hit(input logic [23:0] a, input logic [31:0] d, input logic rw, pc, e0, e1);
      i_cpu.acc(a, d, rw, pc);
      #1 chk(match_0, e0);
      chk(match_1, e1);
      @(posedge clk_sys);
   endtask
   task t_regs;
      for (int i = 0; i < 4; i++) rd(cmp_pkg::ADDR_A_MASK + 12'(i), 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(cmp_pkg::ADDR_A_MASK + 12'(i), 8'(32'hFF00FFF0 >> (24 - 8 * i)));
      end
      rd(cmp_pkg::ADDR_A_MASK + 12'h003, 8'hF0);
      for (int i = 0; i < 4; i++) begin
         wr(cmp_pkg::ADDR_A_DATA + 12'(i), 8'(32'h11223344 >> (24 - 8 * i)));
      end
      for (int i = 0; i < 4; i++) rd(cmp_pkg::ADDR_A_DATA + 12'(i), 8'(8'h11 * (i + 1)));
      for (int i = 0; i < 4; i++) begin
         rd(cmp_pkg::ADDR_A_MASK + 12'(i), 8'(32'hFF00FFF0 >> (24 - 8 * i)));
      end
      rd(12'h000, 8'h00);
   endtask
   task t_armed;
      arm <= 1'b1;
      wr(cmp_pkg::ADDR_A_DATA, 8'hEE);
      rd(cmp_pkg::ADDR_A_DATA, 8'h11);
      arm <= 1'b0;
   endtask
   task t_data_a;
      for (int i = 0; i < 3; i++) begin
         wr(cmp_pkg::ADDR_A_ADDR + 12'(i), 8'(24'h123456 >> (16 - 8 * i)));
      end
      wr(cmp_pkg::ADDR_A_CTRL, 8'h01);
      idle;
      hit(24'h123456, 32'h11AB334F, 1'b1, 1'b0, 1'b1, 1'b0);
      hit(24'h123456, 32'h11223354, 1'b0, 1'b0, 1'b0, 1'b0);
      hit(24'h123457, 32'h11223344, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(cmp_pkg::ADDR_A_CTRL, 8'h41);
      idle;
      hit(24'h123456, 32'h11223354, 1'b0, 1'b0, 1'b1, 1'b0);
      hit(24'h123456, 32'h11223344, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(cmp_pkg::ADDR_A_CTRL, 8'h61);
      idle;
      hit(24'h123456, 32'h11223344, 1'b0, 1'b1, 1'b1, 1'b0);
   endtask
   task t_b;
      for (int i = 0; i < 3; i++) begin
         wr(cmp_pkg::ADDR_B_ADDR + 12'(i), 8'(24'hABCDEF >> (16 - 8 * i)));
      end
      foreach (rows[i]) begin
         wr(cmp_pkg::ADDR_B_CTRL, rows[i][11:4]);
         idle;
         hit(24'hABCDEF, 32'h0, rows[i][2], rows[i][1], 1'b0, rows[i][0]);
      end
      wr(cmp_pkg::ADDR_B_CTRL, 8'h01);
      idle;
      rng <= 1'b1;
      hit(24'hABCDEF, 32'h0, 1'b1, 1'b0, 1'b0, 1'b0);
      rng <= 1'b0;
   endtask
   task t_irq;
      int n;
      n = 0;
      wr(cmp_pkg::ADDR_IRQ_MASK, 8'h02);
      idle;
      hit(24'hABCDEF, 32'h0, 1'b1, 1'b0, 1'b0, 1'b1);
      while (irq !== 1'b1 && n < 4) begin
         @(posedge clk_sys);
         n++;
      end
      #1 chk(irq, 1'b1);
      @(posedge clk_sys);
      wr(cmp_pkg::ADDR_IRQ_STAT, 8'h03);
      wr(cmp_pkg::ADDR_IRQ_MASK, 8'h00);
      idle;
      hit(24'hABCDEF, 32'h0, 1'b0, 1'b0, 1'b0, 1'b1);
      idle;
      idle;
      #1 chk(irq, 1'b0);
      rd(cmp_pkg::ADDR_IRQ_STAT, 8'h02);
      // A clear that meets a new match in the same cycle must leave the bit set.
      {reg_addr, reg_wdata, reg_wr} <= {cmp_pkg::ADDR_IRQ_STAT, 8'h02, 1'b1};
      i_cpu.acc(24'hABCDEF, 32'h0, 1'b0, 1'b0);
      rd(cmp_pkg::ADDR_IRQ_STAT, 8'h02);
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         give_verdict;
      end
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_regs;
      t_armed;
      t_data_a;
      t_b;
      t_irq;
      give_verdict;
   end
endmodule
